// >>> hdl/mbs_fifo.sv
// Reply byte buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module mbs_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } mbs_fifo_state_t;

    mbs_fifo_state_t s;
    mbs_fifo_state_t next_s;

    // Extra pointer bit tells full from empty
    assign in_ready  = (s.wp ^ s.rp) != {1'b1, {AW{1'b0}}};
    assign out_valid = s.wp != s.rp;
    assign out_data  = s.mem[s.rp[AW-1:0]];

    always_comb begin
        next_s = s;
        if (in_valid && in_ready) begin
            next_s.mem[s.wp[AW-1:0]] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_s.rp = s.rp + 1'b1;
        end
    end

    // Storage itself needs no reset; only the pointers do
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s.wp <= '0;
            s.rp <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : mbs_fifo
`default_nettype wire

// >>> hdl/mbs_map.sv
// Address translation from Modbus offsets to host memory locations
`timescale 1ns/10ps
`default_nettype none
module mbs_map
    import mbs_pkg::*;
(
    input  wire mbs_kind_t   kind,
    input  wire logic [15:0] host_base,
    input  wire logic [15:0] base_block,
    input  wire logic [15:0] offset,
    output logic      [15:0] addr,
    output logic      [15:0] block,
    output logic      [3:0]  bit_sel
);
    always_comb begin
        addr    = 16'h0000;
        block   = 16'h0000;
        bit_sel = 4'h0;
        case (kind)
            KIND_BYTE: begin
                addr    = host_base + (offset >> 3);         // R1 R2
                bit_sel = {1'b0, offset[2:0]};               // R3
            end
            KIND_ELEM: begin
                addr    = host_base + (offset >> 4);         // R4
                bit_sel = offset[3:0];
            end
            KIND_WORD: begin
                // Upper field picks the block, 512 words each
                block = base_block + (offset >> 9);          // R11 R13 R18
                addr  = {6'h00, offset[8:0], 1'b0};          // R12 R14
            end
            default: begin
                addr = 16'h0000;
            end
        endcase
    end
endmodule : mbs_map
`default_nettype wire

// >>> hdl/mbs_pkg.sv
// Shared constants, types and helpers of the Modbus read request mapper
`default_nettype none
package mbs_pkg;

    // Function codes served
    localparam logic [7:0]  FN_COILS     = 8'h01;
    localparam logic [7:0]  FN_INPUTS    = 8'h02;
    localparam logic [7:0]  FN_HOLDING   = 8'h03;

    // Exception codes and the flag set in the echoed function code
    localparam logic [7:0]  EXC_NONE     = 8'h00;
    localparam logic [7:0]  EXC_FUNC     = 8'h01;
    localparam logic [7:0]  EXC_ADDR     = 8'h02;
    localparam logic [7:0]  EXC_QTY      = 8'h03;
    localparam logic [7:0]  EXC_FLAG     = 8'h80;

    // Quantity limits
    localparam logic [15:0] BIT_QTY_MAX  = 16'h07F8;
    localparam logic [15:0] REG_QTY_MAX  = 16'h007F;
    localparam logic [15:0] ELEM_QTY_MAX = 16'h0100;
    localparam logic [15:0] BLOCK_WORDS  = 16'h0200;

    // Checksum seed and reflected polynomial
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'hA001;

    // Reply buffer shape: byte plus end-of-frame mark
    localparam int          FIFO_WIDTH   = 9;
    localparam int          FIFO_DEPTH   = 8;

    // Host memory area identifiers on the access port
    localparam logic [2:0]  AREA_MEM     = 3'h0;
    localparam logic [2:0]  AREA_OUT     = 3'h1;
    localparam logic [2:0]  AREA_TIM     = 3'h2;
    localparam logic [2:0]  AREA_CNT     = 3'h3;
    localparam logic [2:0]  AREA_INP     = 3'h4;
    localparam logic [2:0]  AREA_BLK     = 3'h5;

    typedef enum logic [1:0] {KIND_BYTE, KIND_ELEM, KIND_WORD} mbs_kind_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CHK, ST_HDR, ST_FETCH, ST_WAIT, ST_BITS,
        ST_PUSHB, ST_WHI, ST_WLO, ST_CRCL, ST_CRCH
    } mbs_state_t;

    // One byte through the reflected checksum
    function automatic logic [15:0] mbs_crc_step(input logic [15:0] crc,
                                                input logic [7:0]  d);
        logic [15:0] c;
        c = crc ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : mbs_crc_step

    // A new source byte or element starts at this bit offset
    function automatic logic mbs_need_fetch(input mbs_kind_t   k,
                                            input logic [15:0] off);
        return (k == KIND_ELEM) ? (off[3:0] == 4'h0) : (off[2:0] == 3'h0);
    endfunction : mbs_need_fetch

endpackage : mbs_pkg
`default_nettype wire

// >>> hdl/mbs_reader.sv
// Modbus read request interpreter for coils, inputs and holding registers
//
// Behaviour
// R1: Coil byte address is host base plus address offset over 8.
// R2: Input status uses the same byte formula with its own bases.
// R3: Bit within the byte is the address offset modulo 8.
// R4: Timer or counter index is host base plus offset over 16.
// R5: Timer or counter offset not a multiple of 16 is invalid.
// R6: Bit quantity must be 1 to 2040; exactly that many are returned.
// R7: Timer or counter bit quantity must be a multiple of 16.
// R8: At most 16 timer or counter elements per request.
// R9: Input reply: address, function, byte count, packed bytes, checksum.
// R10: Register reply: address, function, count, words high byte first, sum.
// R11: Block number is base block plus upper address field.
// R12: Word byte offset is twice the lower word field.
// R13: Address splits into 512-word blocks.
// R14: Word byte offsets are always even.
// R15: Register quantity must be 1 to 127; that many are returned.
// R16: Quantity may not run past the 512-word block end.
// R17: Each bit group holds Modbus base and host base pairs.
// R18: Register address 0 maps to base block, word 0.
// R19: A register request crossing a block boundary is an error.
// R20: Coil reply carries bits read from mapped areas, packed.
// R21: Invalid requests get an exception reply and raise the error flag.
// R22: First bit in LSB of first byte; unused high bits are zero.
`timescale 1ns/10ps
`default_nettype none
module mbs_reader
    import mbs_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic [7:0]       slave_addr,
    input  wire logic [3:0][15:0] cfg_coil_mb_base,
    input  wire logic [3:0][15:0] cfg_coil_host_area_base,
    input  wire logic [1:0][15:0] cfg_inp_mb_base,
    input  wire logic [1:0][15:0] cfg_inp_host_area_base,
    input  wire logic [15:0]      base_block_number,
    input  wire logic             req_valid,
    output logic                  req_ready,
    input  wire logic [7:0]       req_func,
    input  wire logic [15:0]      req_start,
    input  wire logic [15:0]      req_qty,
    output logic                  mem_req,
    output logic      [2:0]       mem_area,
    output logic      [15:0]      mem_addr,
    output logic      [15:0]      mem_data_block,
    input  wire logic             mem_ack,
    input  wire logic [15:0]      mem_rdata,
    output logic                  rsp_valid,
    input  wire logic             rsp_ready,
    output logic      [7:0]       rsp_data,
    output logic                  rsp_last,
    output logic                  err,
    output logic      [7:0]       err_code
);

    typedef struct packed {
        mbs_state_t  st;
        logic [7:0]  fn;
        logic [15:0] start;
        logic [15:0] qty;
        mbs_kind_t   kind;
        logic [2:0]  area;
        logic [15:0] hbase;
        logic [15:0] off;
        logic [15:0] remain;
        logic [7:0]  cnt;
        logic [7:0]  exc;
        logic [1:0]  idx;
        logic [15:0] cache;
        logic [7:0]  ob;
        logic [2:0]  obit;
        logic [15:0] crc;
        logic        mem_req;
        logic [15:0] mem_addr;
        logic [15:0] mem_block;
        logic        err;
    } mbs_reader_state_t;

    mbs_reader_state_t s;
    mbs_reader_state_t next_s;

    // Translation of the running offset
    logic [15:0] map_addr;
    logic [15:0] map_block;
    logic [3:0]  map_bit;

    // Request decode results, valid while checking
    logic        c_found;
    logic [15:0] c_best;
    logic [15:0] c_hb;
    logic [2:0]  c_area;
    mbs_kind_t   c_kind;
    logic [15:0] c_off;
    logic [7:0]  c_code;
    logic [15:0] c_end;

    // Reply byte stream into the buffer
    logic        push_v;
    logic [7:0]  push_d;
    logic        push_l;
    logic        go;
    logic        f_in_ready;

    mbs_map u_map (
        .kind       (s.kind),
        .host_base  (s.hbase),
        .base_block (base_block_number),
        .offset     (s.off),
        .addr       (map_addr),
        .block      (map_block),
        .bit_sel    (map_bit)
    );

    // Reply buffer absorbs stalls of the serial side
    mbs_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (push_v),
        .in_ready  (f_in_ready),
        .in_data   ({push_l, push_d}),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  ({rsp_last, rsp_data})
    );

    assign go             = push_v && f_in_ready;
    assign req_ready      = s.st == ST_IDLE;
    assign mem_req        = s.mem_req;
    assign mem_area       = s.area;
    assign mem_addr       = s.mem_addr;
    assign mem_data_block = s.mem_block;
    assign err            = s.err;
    assign err_code       = s.exc;

    // Area pick: the highest configured base not above the address
    always_comb begin
        c_found = 1'b0;
        c_best  = 16'h0000;
        c_hb    = 16'h0000;
        c_area  = AREA_MEM;
        if (s.fn == FN_COILS) begin
            for (int i = 0; i < 4; i++) begin
                if (s.start >= cfg_coil_mb_base[i] &&
                    (!c_found || cfg_coil_mb_base[i] >= c_best)) begin
                    c_found = 1'b1;                          // R17
                    c_best  = cfg_coil_mb_base[i];
                    c_hb    = cfg_coil_host_area_base[i];
                    c_area  = 3'(i);
                end
            end
        end else if (s.fn == FN_INPUTS) begin
            for (int i = 0; i < 2; i++) begin
                if (s.start >= cfg_inp_mb_base[i] &&
                    (!c_found || cfg_inp_mb_base[i] >= c_best)) begin
                    c_found = 1'b1;                          // R17 R2
                    c_best  = cfg_inp_mb_base[i];
                    c_hb    = cfg_inp_host_area_base[i];
                    c_area  = (i == 0) ? AREA_MEM : AREA_INP;
                end
            end
        end else begin
            c_area = AREA_BLK;
        end
        c_off = s.start - c_best;
        c_end = {7'h00, s.start[8:0]} + s.qty;
    end

    // Request checks; function first, then quantity, then address
    always_comb begin
        c_kind = KIND_BYTE;
        c_code = EXC_NONE;
        if (s.fn == FN_HOLDING) begin
            c_kind = KIND_WORD;
        end else if (c_area == AREA_TIM || c_area == AREA_CNT) begin
            c_kind = KIND_ELEM;
        end
        if (s.fn != FN_COILS && s.fn != FN_INPUTS &&
            s.fn != FN_HOLDING) begin
            c_code = EXC_FUNC;
        end else if (c_kind == KIND_WORD) begin
            if (s.qty == 16'h0000 || s.qty > REG_QTY_MAX) begin
                c_code = EXC_QTY;                            // R15
            end else if (c_end > BLOCK_WORDS) begin
                c_code = EXC_ADDR;                           // R16 R19
            end
        end else if (s.qty == 16'h0000 || s.qty > BIT_QTY_MAX) begin
            c_code = EXC_QTY;                                // R6
        end else if (c_kind == KIND_ELEM &&
                     (s.qty[3:0] != 4'h0 || s.qty > ELEM_QTY_MAX)) begin
            c_code = EXC_QTY;                                // R7 R8
        end else if (!c_found) begin
            c_code = EXC_ADDR;
        end else if (c_kind == KIND_ELEM && c_off[3:0] != 4'h0) begin
            c_code = EXC_ADDR;                               // R5
        end
    end

    // Byte offered to the reply buffer in each state
    always_comb begin
        push_v = 1'b0;
        push_d = 8'h00;
        push_l = 1'b0;
        case (s.st)
            ST_HDR: begin
                push_v = 1'b1;
                if (s.idx == 2'h0) begin
                    push_d = slave_addr;
                end else if (s.idx == 2'h1) begin
                    push_d = (s.exc != EXC_NONE) ? (s.fn | EXC_FLAG)
                                                 : s.fn;     // R21
                end else begin
                    push_d = (s.exc != EXC_NONE) ? s.exc : s.cnt;
                end
            end
            ST_PUSHB: begin
                push_v = 1'b1;
                push_d = s.ob;                               // R9 R20
            end
            ST_WHI: begin
                push_v = 1'b1;
                push_d = s.cache[15:8];                      // R10
            end
            ST_WLO: begin
                push_v = 1'b1;
                push_d = s.cache[7:0];
            end
            ST_CRCL: begin
                push_v = 1'b1;
                push_d = s.crc[7:0];
            end
            ST_CRCH: begin
                push_v = 1'b1;
                push_d = s.crc[15:8];
                push_l = 1'b1;
            end
            default: begin
                push_v = 1'b0;
            end
        endcase
    end

    // Sequencer: check, header, data fetch and pack, checksum
    always_comb begin
        next_s = s;
        if (go && s.st != ST_CRCL && s.st != ST_CRCH) begin
            next_s.crc = mbs_crc_step(s.crc, push_d);
        end
        case (s.st)
            ST_IDLE: begin
                if (req_valid) begin
                    next_s.fn    = req_func;
                    next_s.start = req_start;
                    next_s.qty   = req_qty;
                    next_s.crc   = CRC_INIT;
                    next_s.exc   = EXC_NONE;
                    next_s.err   = 1'b0;
                    next_s.st    = ST_CHK;
                end
            end
            ST_CHK: begin
                next_s.kind   = c_kind;
                next_s.area   = c_area;
                next_s.hbase  = c_hb;
                next_s.off    = (c_kind == KIND_WORD) ? s.start : c_off;
                next_s.remain = s.qty;
                next_s.cnt    = (c_kind == KIND_WORD) ? 8'(s.qty << 1)
                                : 8'((s.qty + 16'h0007) >> 3);
                next_s.exc    = c_code;
                next_s.err    = c_code != EXC_NONE;          // R21
                next_s.idx    = 2'h0;
                next_s.ob     = 8'h00;
                next_s.obit   = 3'h0;
                next_s.st     = ST_HDR;
            end
            ST_HDR: begin
                if (go) begin
                    next_s.idx = s.idx + 2'h1;
                    if (s.idx == 2'h2) begin
                        next_s.st = (s.exc != EXC_NONE) ? ST_CRCL
                                                        : ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                next_s.mem_req   = 1'b1;
                next_s.mem_addr  = map_addr;
                next_s.mem_block = map_block;
                next_s.st        = ST_WAIT;
            end
            ST_WAIT: begin
                // Request holds until the host memory answers
                if (mem_ack) begin
                    next_s.mem_req = 1'b0;
                    next_s.cache   = mem_rdata;
                    next_s.st = (s.kind == KIND_WORD) ? ST_WHI : ST_BITS;
                end
            end
            ST_BITS: begin
                next_s.ob[s.obit] = s.cache[map_bit];        // R22
                next_s.off    = s.off + 16'h0001;
                next_s.remain = s.remain - 16'h0001;
                next_s.obit   = s.obit + 3'h1;
                if (s.obit == 3'h7 || s.remain == 16'h0001) begin
                    next_s.st = ST_PUSHB;
                end else if (mbs_need_fetch(s.kind,
                                            s.off + 16'h0001)) begin
                    next_s.st = ST_FETCH;
                end
            end
            ST_PUSHB: begin
                if (go) begin
                    // Cleared byte gives zero fill of the last one
                    next_s.ob   = 8'h00;                     // R22
                    next_s.obit = 3'h0;
                    if (s.remain == 16'h0000) begin
                        next_s.st = ST_CRCL;                 // R6
                    end else if (mbs_need_fetch(s.kind, s.off)) begin
                        next_s.st = ST_FETCH;
                    end else begin
                        next_s.st = ST_BITS;
                    end
                end
            end
            ST_WHI: begin
                if (go) begin
                    next_s.st = ST_WLO;                      // R10
                end
            end
            ST_WLO: begin
                if (go) begin
                    next_s.off    = s.off + 16'h0001;
                    next_s.remain = s.remain - 16'h0001;
                    next_s.st = (s.remain == 16'h0001) ? ST_CRCL
                                                       : ST_FETCH; // R15
                end
            end
            ST_CRCL: begin
                if (go) begin
                    next_s.st = ST_CRCH;
                end
            end
            ST_CRCH: begin
                if (go) begin
                    next_s.st = ST_IDLE;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    // Single state register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s       <= '0;
            s.st    <= ST_IDLE;
            s.kind  <= KIND_BYTE;
            s.crc   <= CRC_INIT;
        end else begin
            s <= next_s;
        end
    end

    property p_bit_qty;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_CHK && (s.fn == FN_COILS || s.fn == FN_INPUTS) &&
        (s.qty == 16'h0000 || s.qty > BIT_QTY_MAX)
        |=> s.exc == EXC_QTY && err;
    endproperty
    a_bit_qty: assert property (p_bit_qty) // R6
        else $error("bad bit quantity not refused");

    property p_reg_qty;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_CHK && s.fn == FN_HOLDING &&
        (s.qty == 16'h0000 || s.qty > REG_QTY_MAX) |=> s.exc == EXC_QTY;
    endproperty
    a_reg_qty: assert property (p_reg_qty) // R15
        else $error("bad register quantity not refused");

    property p_elem_max;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_CHK && c_kind == KIND_ELEM && s.qty > ELEM_QTY_MAX
        |=> s.exc == EXC_QTY;
    endproperty
    a_elem_max: assert property (p_elem_max) // R8
        else $error("too many timer or counter elements accepted");

    property p_elem_align;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_CHK && c_kind == KIND_ELEM && c_off[3:0] != 4'h0
        |=> s.exc == EXC_ADDR || s.exc == EXC_QTY;
    endproperty
    a_elem_align: assert property (p_elem_align) // R5
        else $error("misaligned element access accepted");

    property p_block_cross;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_CHK && s.fn == FN_HOLDING && s.qty != 16'h0000 &&
        s.qty <= REG_QTY_MAX && c_end > BLOCK_WORDS
        |=> s.exc == EXC_ADDR;
    endproperty
    a_block_cross: assert property (p_block_cross) // R19
        else $error("block crossing read accepted");

    property p_even;
        @(posedge core_clk) disable iff (!resetn)
        mem_req && s.kind == KIND_WORD |-> !mem_addr[0];
    endproperty
    a_even: assert property (p_even) // R14
        else $error("odd word byte offset issued");

    property p_block_no;
        @(posedge core_clk) disable iff (!resetn)
        mem_req && s.kind == KIND_WORD |->
        mem_data_block == 16'(base_block_number + (s.off >> 9));
    endproperty
    a_block_no: assert property (p_block_no) // R11
        else $error("wrong data block number");

    property p_word_order;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_WHI && go |=> s.st == ST_WLO ##0 push_d == s.cache[7:0];
    endproperty
    a_word_order: assert property (p_word_order) // R10
        else $error("low byte did not follow high byte");

    property p_exc_reply;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_HDR && s.idx == 2'h1 && s.exc != EXC_NONE
        |-> push_d == (s.fn | EXC_FLAG) && err;
    endproperty
    a_exc_reply: assert property (p_exc_reply) // R21
        else $error("exception reply lacks flag");

    property p_last_bit;
        @(posedge core_clk) disable iff (!resetn)
        s.st == ST_BITS && s.remain == 16'h0001 |=> s.st == ST_PUSHB;
    endproperty
    a_last_bit: assert property (p_last_bit) // R22
        else $error("partial last byte not sent");

endmodule : mbs_reader
`default_nettype wire

// >>> verif/mbs_host_mem.sv
// Host memory model answering the mapper's access port
`timescale 1ns/10ps
`default_nettype none
module mbs_host_mem (
    input  wire logic        core_clk,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack = 1'b0,
    output logic      [15:0] mem_rdata
);
    logic [15:0] val;
    logic [1:0]  wait_cnt = 2'h0;
    logic        slow     = 1'b0;
    assign val = {mem_addr[7:0] ^ 8'hC3, mem_addr[7:0] ^ 8'h5A};
    // Data is only good in the ack cycle, so a late sample shows up
    assign mem_rdata = mem_ack ? val : ~val;
    // Every other access is answered two cycles late
    always @(posedge core_clk) begin
        mem_ack <= mem_req && !mem_ack && wait_cnt == 2'h0;
        if (mem_req && !mem_ack && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
        if (mem_req && !mem_ack && wait_cnt == 2'h0) begin
            slow     <= !slow;
            wait_cnt <= slow ? 2'h0 : 2'h2;
        end
    end
endmodule : mbs_host_mem
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench of the Modbus read request mapper
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mbs_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0;
    logic rsp_ready = 1'b1, got = 1'b0, mseen = 1'b0;
    logic [7:0]  req_func = 8'h00;
    logic [15:0] req_start = 16'h0000, req_qty = 16'h0000;
    logic [3:0][15:0] cmb = {16'h0FE0, 16'h0800, 16'h0400, 16'h0000};
    logic [3:0][15:0] chb = {16'h00C8, 16'h0064, 16'h0064, 16'h03E8};
    logic [1:0][15:0] imb = {16'h0400, 16'h0000};
    logic [1:0][15:0] ihb = {16'h0064, 16'h03E8};
    logic req_ready, mem_req, mem_ack, rsp_valid, rsp_last, err;
    logic [2:0]  mem_area, m_area;
    logic [15:0] mem_addr, mem_data_block, mem_rdata, m_addr, m_blk;
    logic [7:0]  rsp_data, err_code;
    logic [7:0]  rx[$];
    int num_errors = 0, compares = 0;
    mbs_reader dut_u (.core_clk(core_clk), .resetn(resetn),
        .slave_addr(8'h11), .cfg_coil_mb_base(cmb),
        .cfg_coil_host_area_base(chb), .cfg_inp_mb_base(imb),
        .cfg_inp_host_area_base(ihb), .base_block_number(16'h0320),
        .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
        .req_start(req_start), .req_qty(req_qty), .mem_req(mem_req),
        .mem_area(mem_area), .mem_addr(mem_addr),
        .mem_data_block(mem_data_block), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last),
        .err(err), .err_code(err_code));
    mbs_host_mem host_u (.core_clk(core_clk), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always #5 core_clk = ~core_clk;
    // Collect reply bytes and the first memory access of each request
    always @(posedge core_clk) begin
        if (rsp_valid && rsp_ready) begin
            rx.push_back(rsp_data);
            got = rsp_last;
        end
        if (mem_req && mem_ack && !mseen) begin
            {m_area, m_addr, m_blk} = {mem_area, mem_addr, mem_data_block};
            mseen = 1'b1;
        end
    end
    function automatic logic [15:0] hw(input logic [15:0] a);
        return {a[7:0] ^ 8'hC3, a[7:0] ^ 8'h5A};
    endfunction : hw
    task automatic check(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // Send one request; a nonzero stall holds off the reply side
    task automatic run(input logic [7:0] f, input logic [15:0] s, q,
                       input int st, input int len);
        logic [15:0] c;
        rx = {};
        {got, mseen, c} = {2'b00, 16'hFFFF};
        @(negedge core_clk);
        {req_func, req_start, req_qty, req_valid} = {f, s, q, 1'b1};
        rsp_ready = (st == 0);
        @(negedge core_clk);
        req_valid = 1'b0;
        for (int i = 0; i < 600 && !got; i++) begin
            @(negedge core_clk);
            if (i == st) rsp_ready = 1'b1;
        end
        check("len", rx.size(), len[15:0]);
        if (rx.size() < 3) return;
        check("addr", rx[0], 16'h0011);
        for (int i = 0; i < rx.size() - 2; i++) begin
            c ^= {8'h00, rx[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? c >> 1 ^ 16'hA001 : c >> 1;
        end
        check("crc", {rx[$], rx[$-1]}, c);
    endtask : run
    task automatic final_report;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    initial begin
        #300000;
        num_errors++;
        final_report();
    end
    initial begin
        logic [7:0]  ef[8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h03,
                               8'h04, 8'h01};
        logic [15:0] es[8] = '{16'h0811, 16'h0800, 16'h0000, 16'h0FF0,
                               16'h0000, 16'h01F4, 16'h0000, 16'h0000};
        logic [15:0] eq[8] = '{16'h0010, 16'h0011, 16'h07F9, 16'h0110,
                               16'h0080, 16'h000D, 16'h0001, 16'h0000};
        logic [7:0]  ec[8] = '{8'h02, 8'h03, 8'h03, 8'h03, 8'h03, 8'h02,
                               8'h01, 8'h03};
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            run(ef[i], es[i], eq[i], 0, 5);
            check("exc", rx[1], ef[i] | EXC_FLAG);
            check("code", rx[2], ec[i]);
            check("ecode", err_code, ec[i]);
            check("err", err, 1'b1);
        end
        run(FN_COILS, 16'h0401, 16'h0003, 0, 6);
        check("out", {m_area, m_addr}, {AREA_OUT, 16'h0064});
        check("obit", rx[3], (hw(16'h0064) >> 1) & 16'h0007);
        run(FN_INPUTS, 16'h07DA, 16'h0001, 0, 6);
        check("inp", {m_area, m_addr}, {AREA_INP, 16'h00DF});
        check("ibit", {rx[2], rx[3]}, 16'h0101);
        check("err", err, 1'b0);
        run(FN_COILS, 16'h0810, 16'h0010, 0, 7);
        check("tim", {m_area, m_addr}, {AREA_TIM, 16'h0065});
        check("tbits", {rx[4], rx[3]}, hw(16'h0065));
        run(FN_HOLDING, 16'h0384, 16'h0002, 40, 9);
        check("blk", {m_area, m_blk}, {AREA_BLK, 16'h0321});
        check("dbw", m_addr, 16'h0308);
        check("word", {rx[3], rx[4]}, hw(16'h0308));
        run(FN_HOLDING, 16'h0000, 16'h0001, 0, 7);
        check("base", {m_blk, m_addr}, {16'h0320, 16'h0000});
        final_report();
    end
endmodule : testbench
`default_nettype wire
